// [verilog/tsop_top.sv]
// Behaviour
// R1 - two RS-232 time ports, selectable format
// R2 - time port: on request or every second
// R3 - request char: symbol, digit or capital
// R4 - request char resets to capital T
// R5 - invalid received char answered with asterisk
// R6 - far end sends no terminator after request
// R7 - DCE: output on RXD, input on TXD
// R8 - no flow control; RTS to CTS, DSR high
// R9 - time ports: 8 data, no parity, 1 stop
// R10 - two RS-485 outputs stream once per second
// R11 - time port: format, baud, offset, mode each
// R12 - remote output: format, baud, offset each
// R13 - RS-485 mark drives A below B
// R14 - setup port fixed 9600 baud 8N1
// R15 - setup port carries configuration commands
// R16 - setup port honours XON/XOFF
// R17 - setup port carries firmware image bytes
// R18 - streaming ports start on common tick
// R19 - start bit, data LSB first, stop, idle mark
//
// The implementer's own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/100ps
module tsop_top
   import tsop_pkg::*;
#(
   parameter int FIFO_DEPTH = 2
)(
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic pps_tick_i,
   input wire logic [11:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [11:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   input wire logic [N_RX-1:0] ser_txd_i,
   output logic [N_RX-1:0] ser_rxd_o,
   input wire logic [N_RX-1:0] ser_rts_i,
   output logic [N_RX-1:0] ser_cts_o,
   output logic [N_RX-1:0] ser_dsr_o,
   output logic [1:0] rs485_a_o,
   output logic [1:0] rs485_b_o
);
   tsop_cfg_t cfg_ff [N_OUT];
   logic [5:0] mlen_ff [N_FMT];
   logic [7:0] msg_mem [N_FMT*MSG_BYTES];
   logic [7:0] fifo_mem [FIFO_DEPTH];
   logic [$clog2(FIFO_DEPTH+1)-1:0] fifo_cnt_ff;
   logic [$clog2(FIFO_DEPTH)-1:0] fifo_wp_ff;
   logic [$clog2(FIFO_DEPTH)-1:0] fifo_rp_ff;
   logic fifo_full;
   logic fifo_empty;
   logic fifo_push;
   logic fifo_pop;
   logic [9:0] rx_hold_ff;
   logic xoff_ff;
   logic aw_hold_ff;
   logic w_hold_ff;
   logic [11:0] awaddr_ff;
   logic [31:0] wdata_ff;
   logic [3:0] wstrb_ff;
   logic wr_go;
   logic wr_map;
   logic rd_pop;
   logic [31:0] rd_data;
   logic rd_map;
   tsop_txs_t tx_st_ff [N_TX];
   logic [N_TX-1:0] tx_line_ff;
   logic [N_TX-1:0] tx_load;
   logic [7:0] tx_byte [N_TX];
   logic [N_OUT-1:0] msg_act_ff;
   logic [N_OUT-1:0] star_ff;
   logic [5:0] msg_idx_ff [N_OUT];
   logic [N_RX-1:0] rx_stb_ff;
   logic [7:0] rx_byte_ff [N_RX];

   // bus slave: address and data are taken in either order
   assign wr_go = aw_hold_ff && w_hold_ff && !s_axi_bvalid_o &&
      !(awaddr_ff == ADDR_SETUP_TX && fifo_full);
   assign wr_map = (awaddr_ff == ADDR_SETUP_TX) ||
      (awaddr_ff >= ADDR_CFG && awaddr_ff < ADDR_CFG + 12'h010) ||
      (awaddr_ff >= ADDR_DIV && awaddr_ff < ADDR_DIV + 12'h010) ||
      (awaddr_ff >= ADDR_MLEN && awaddr_ff < ADDR_MLEN + 12'h018) ||
      (awaddr_ff >= ADDR_MSG && awaddr_ff < ADDR_MSG_END);

   always_ff @(posedge sys_clk_i)
   begin
      if (!nrst_i)
      begin
         aw_hold_ff <= 1'b0;
         w_hold_ff <= 1'b0;
         awaddr_ff <= 12'h000;
         wdata_ff <= 32'h0000_0000;
         wstrb_ff <= 4'h0;
         s_axi_awready_o <= 1'b0;
         s_axi_wready_o <= 1'b0;
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o <= RESP_OKAY;
      end
      else
      begin
         s_axi_awready_o <= !aw_hold_ff && !(s_axi_awvalid_i && s_axi_awready_o);
         s_axi_wready_o <= !w_hold_ff && !(s_axi_wvalid_i && s_axi_wready_o);
         if (s_axi_awvalid_i && s_axi_awready_o)
         begin
            aw_hold_ff <= 1'b1;
            awaddr_ff <= {s_axi_awaddr_i[11:2], 2'b00};
         end
         if (s_axi_wvalid_i && s_axi_wready_o)
         begin
            w_hold_ff <= 1'b1;
            wdata_ff <= s_axi_wdata_i;
            wstrb_ff <= s_axi_wstrb_i;
         end
         if (wr_go)
         begin
            aw_hold_ff <= 1'b0;
            w_hold_ff <= 1'b0;
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o <= wr_map ? RESP_OKAY : RESP_SLVERR;
         end
         else if (s_axi_bvalid_o && s_axi_bready_i)
            s_axi_bvalid_o <= 1'b0;
      end
   end

   // configuration registers, one set per time port and remote output
   always_ff @(posedge sys_clk_i)
   begin
      if (!nrst_i)
      begin
         for (int p = 0; p < N_OUT; p++)
         begin
            cfg_ff[p].utc <= 8'h00;
            cfg_ff[p].req <= REQ_CHAR_RST; // R4
            cfg_ff[p].cont <= 1'b0;
            cfg_ff[p].fmt <= 3'h0;
            cfg_ff[p].div <= SETUP_DIV;
         end
         for (int f = 0; f < N_FMT; f++)
            mlen_ff[f] <= 6'h00;
      end
      else if (wr_go)
      begin
         for (int p = 0; p < N_OUT; p++)
         begin
            if (awaddr_ff == ADDR_CFG + 12'(4 * p))
            begin
               // R11 R12
               if (wstrb_ff[0] && wdata_ff[CFG_FMT_LSB +: 3] <= FMT_MAX)
                  cfg_ff[p].fmt <= wdata_ff[CFG_FMT_LSB +: 3];
               if (wstrb_ff[0] && p < N_TIME)
                  cfg_ff[p].cont <= wdata_ff[CFG_CONT_BIT]; // R2
               if (wstrb_ff[1] && wdata_ff[CFG_REQ_LSB +: 8] >= REQ_LO &&
                   wdata_ff[CFG_REQ_LSB +: 8] <= REQ_HI &&
                   !(wdata_ff[CFG_REQ_LSB +: 8] >= LOWER_LO &&
                     wdata_ff[CFG_REQ_LSB +: 8] <= LOWER_HI))
                  cfg_ff[p].req <= wdata_ff[CFG_REQ_LSB +: 8]; // R3
               if (wstrb_ff[2])
                  cfg_ff[p].utc <= wdata_ff[CFG_UTC_LSB +: 8];
            end
            if (awaddr_ff == ADDR_DIV + 12'(4 * p) && &wstrb_ff[1:0] &&
                wdata_ff[15:0] != 16'h0000)
               cfg_ff[p].div <= wdata_ff[15:0];
         end
         for (int f = 0; f < N_FMT; f++)
            if (awaddr_ff == ADDR_MLEN + 12'(4 * f) && wstrb_ff[0] &&
                wdata_ff[5:0] <= 6'(MSG_BYTES))
               mlen_ff[f] <= wdata_ff[5:0];
      end
   end

   // message text per format, filled by software
   always_ff @(posedge sys_clk_i)
   begin
      if (wr_go && wstrb_ff[0] && awaddr_ff >= ADDR_MSG && awaddr_ff < ADDR_MSG_END)
         msg_mem[8'((awaddr_ff - ADDR_MSG) >> 2)] <= wdata_ff[7:0];
   end

   // read side
   assign rd_map = (s_axi_araddr_i[11:2] <= ADDR_SETUP_RX[11:2]) ||
      (s_axi_araddr_i >= ADDR_CFG && s_axi_araddr_i < ADDR_CFG + 12'h020) ||
      (s_axi_araddr_i >= ADDR_MLEN && s_axi_araddr_i < ADDR_MLEN + 12'h018);
   assign rd_pop = s_axi_arvalid_i && s_axi_arready_o &&
      s_axi_araddr_i[11:2] == ADDR_SETUP_RX[11:2];

   always_comb
   begin
      rd_data = 32'h0000_0000;
      case (s_axi_araddr_i[11:2])
         ADDR_STAT[11:2]: rd_data = {21'h00_0000, !fifo_empty, xoff_ff, msg_act_ff,
                                     tx_st_ff[4] != TXS_IDLE, tx_line_ff[3:0]};
         ADDR_SETUP_RX[11:2]: rd_data = {22'h00_0000, rx_hold_ff};
         default:
         begin
            for (int p = 0; p < N_OUT; p++)
            begin
               if (s_axi_araddr_i[11:2] == 10'((ADDR_CFG >> 2) + 12'(p)))
                  rd_data = {8'h00, cfg_ff[p].utc, cfg_ff[p].req, 4'h0,
                             cfg_ff[p].cont, cfg_ff[p].fmt};
               if (s_axi_araddr_i[11:2] == 10'((ADDR_DIV >> 2) + 12'(p)))
                  rd_data = {16'h0000, cfg_ff[p].div};
            end
            for (int f = 0; f < N_FMT; f++)
               if (s_axi_araddr_i[11:2] == 10'((ADDR_MLEN >> 2) + 12'(f)))
                  rd_data = {26'h000_0000, mlen_ff[f]};
         end
      endcase
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (!nrst_i)
      begin
         s_axi_arready_o <= 1'b0;
         s_axi_rvalid_o <= 1'b0;
         s_axi_rdata_o <= 32'h0000_0000;
         s_axi_rresp_o <= RESP_OKAY;
      end
      else if (s_axi_arvalid_i && s_axi_arready_o)
      begin
         s_axi_arready_o <= 1'b0;
         s_axi_rvalid_o <= 1'b1;
         s_axi_rdata_o <= rd_map ? rd_data : 32'h0000_0000;
         s_axi_rresp_o <= rd_map ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rvalid_o && s_axi_rready_i)
         s_axi_rvalid_o <= 1'b0;
      else
         s_axi_arready_o <= !s_axi_rvalid_o;
   end

   // setup port received byte holder; commands and image bytes go to software
   always_ff @(posedge sys_clk_i)
   begin
      if (!nrst_i)
      begin
         rx_hold_ff <= 10'h000;
         xoff_ff <= 1'b0;
      end
      else
      begin
         if (rd_pop)
            rx_hold_ff[RX_VALID_BIT] <= 1'b0;
         if (rx_stb_ff[2] && rx_byte_ff[2] == XOFF_CHAR)
            xoff_ff <= 1'b1; // R16
         else if (rx_stb_ff[2] && rx_byte_ff[2] == XON_CHAR)
            xoff_ff <= 1'b0; // R16
         else if (rx_stb_ff[2])
         begin
            // R15 R17
            rx_hold_ff[7:0] <= rx_byte_ff[2];
            rx_hold_ff[RX_VALID_BIT] <= 1'b1;
            rx_hold_ff[RX_OVR_BIT] <= rx_hold_ff[RX_OVR_BIT] |
               (rx_hold_ff[RX_VALID_BIT] & !rd_pop);
         end
         else if (rd_pop)
            rx_hold_ff[RX_OVR_BIT] <= 1'b0;
      end
   end

   // FIFO_DEPTH-entry buffer (two by default) toward the setup transmitter; XOFF stalls its drain
   assign fifo_full = fifo_cnt_ff == ($bits(fifo_cnt_ff))'(FIFO_DEPTH);
   assign fifo_empty = fifo_cnt_ff == '0;
   assign fifo_push = wr_go && awaddr_ff == ADDR_SETUP_TX;
   assign fifo_pop = tx_load[4];

   always_ff @(posedge sys_clk_i)
   begin
      if (!nrst_i)
      begin
         fifo_cnt_ff <= '0;
         fifo_wp_ff <= '0;
         fifo_rp_ff <= '0;
      end
      else
      begin
         if (fifo_push)
         begin
            fifo_mem[fifo_wp_ff] <= wdata_ff[7:0];
            fifo_wp_ff <= fifo_wp_ff + 1'b1;
         end
         if (fifo_pop)
            fifo_rp_ff <= fifo_rp_ff + 1'b1;
         if (fifo_push && !fifo_pop)
            fifo_cnt_ff <= fifo_cnt_ff + 1'b1;
         else if (fifo_pop && !fifo_push)
            fifo_cnt_ff <= fifo_cnt_ff - 1'b1;
      end
   end

   // message sequencers for time ports and remote outputs
   genvar g;
   generate
      for (g = 0; g < N_OUT; g++)
      begin : g_seq
         logic cont;
         logic trig;
         logic bad;
         assign cont = (g >= N_TIME) || cfg_ff[g].cont; // R10
         if (g < N_TIME)
         begin : g_rx
            assign trig = (cont && pps_tick_i) ||
               (!cont && rx_stb_ff[g] && rx_byte_ff[g] == cfg_ff[g].req); // R2 R18
            assign bad = rx_stb_ff[g] && (cont || rx_byte_ff[g] != cfg_ff[g].req);
         end
         else
         begin : g_norx
            assign trig = pps_tick_i; // R10 R18
            assign bad = 1'b0;
         end
         assign tx_load[g] = tx_st_ff[g] == TXS_IDLE &&
            (star_ff[g] || (msg_act_ff[g] && msg_idx_ff[g] < mlen_ff[cfg_ff[g].fmt]));
         assign tx_byte[g] = star_ff[g] ? STAR_CHAR :
            msg_mem[8'(cfg_ff[g].fmt * MSG_BYTES + msg_idx_ff[g])]; // R1

         always_ff @(posedge sys_clk_i)
         begin
            if (!nrst_i)
            begin
               msg_act_ff[g] <= 1'b0;
               msg_idx_ff[g] <= 6'h00;
               star_ff[g] <= 1'b0;
            end
            else
            begin
               if (bad)
                  star_ff[g] <= 1'b1; // R5
               else if (tx_load[g] && star_ff[g])
                  star_ff[g] <= 1'b0;
               if (!msg_act_ff[g] && trig && mlen_ff[cfg_ff[g].fmt] != 6'h00)
               begin
                  msg_act_ff[g] <= 1'b1;
                  msg_idx_ff[g] <= 6'h00;
               end
               else if (tx_load[g] && !star_ff[g])
                  msg_idx_ff[g] <= msg_idx_ff[g] + 6'h01;
               else if (msg_act_ff[g] && tx_st_ff[g] == TXS_IDLE &&
                        msg_idx_ff[g] >= mlen_ff[cfg_ff[g].fmt])
                  msg_act_ff[g] <= 1'b0;
            end
         end
      end
   endgenerate

   assign tx_load[4] = tx_st_ff[4] == TXS_IDLE && !fifo_empty && !xoff_ff; // R16
   assign tx_byte[4] = fifo_mem[fifo_rp_ff];

   // 8N1 transmitters
   generate
      for (g = 0; g < N_TX; g++)
      begin : g_tx
         logic [15:0] div;
         logic [15:0] cnt_ff;
         logic [7:0] sh_ff;
         logic [2:0] nb_ff;
         assign div = (g == 4) ? SETUP_DIV : cfg_ff[g].div; // R14

         always_ff @(posedge sys_clk_i)
         begin
            if (!nrst_i)
            begin
               tx_st_ff[g] <= TXS_IDLE;
               tx_line_ff[g] <= 1'b1;
               cnt_ff <= 16'h0000;
               sh_ff <= 8'h00;
               nb_ff <= 3'h0;
            end
            else
            begin
               cnt_ff <= (cnt_ff == 16'h0000) ? div - 16'h0001 : cnt_ff - 16'h0001;
               case (tx_st_ff[g])
                  TXS_IDLE:
                  begin
                     tx_line_ff[g] <= 1'b1; // R19
                     if (tx_load[g])
                     begin
                        sh_ff <= tx_byte[g];
                        tx_st_ff[g] <= TXS_START;
                        tx_line_ff[g] <= 1'b0; // R19
                        cnt_ff <= div - 16'h0001;
                     end
                  end
                  TXS_START:
                     if (cnt_ff == 16'h0000)
                     begin
                        tx_st_ff[g] <= TXS_DATA;
                        tx_line_ff[g] <= sh_ff[0]; // R19
                        nb_ff <= 3'h0;
                     end
                  TXS_DATA:
                     if (cnt_ff == 16'h0000)
                     begin
                        if (nb_ff == 3'h7)
                        begin
                           tx_st_ff[g] <= TXS_STOP; // R9
                           tx_line_ff[g] <= 1'b1;
                        end
                        else
                        begin
                           nb_ff <= nb_ff + 3'h1;
                           sh_ff <= {1'b0, sh_ff[7:1]};
                           tx_line_ff[g] <= sh_ff[1];
                        end
                     end
                  TXS_STOP:
                     if (cnt_ff == 16'h0000)
                        tx_st_ff[g] <= TXS_IDLE;
                  default:
                     tx_st_ff[g] <= TXS_IDLE;
               endcase
            end
         end
      end
   endgenerate

   // receivers: time ports 0 and 1, setup port 2
   generate
      for (g = 0; g < N_RX; g++)
      begin : g_rx
         tsop_rxs_t st_ff;
         logic [15:0] div;
         logic [15:0] cnt_ff;
         logic [7:0] sh_ff;
         logic [2:0] nb_ff;
         assign div = (g == 2) ? SETUP_DIV : cfg_ff[g].div;

         always_ff @(posedge sys_clk_i)
         begin
            if (!nrst_i)
            begin
               st_ff <= RXS_IDLE;
               cnt_ff <= 16'h0000;
               sh_ff <= 8'h00;
               nb_ff <= 3'h0;
               rx_stb_ff[g] <= 1'b0;
               rx_byte_ff[g] <= 8'h00;
            end
            else
            begin
               rx_stb_ff[g] <= 1'b0;
               cnt_ff <= (cnt_ff == 16'h0000) ? div - 16'h0001 : cnt_ff - 16'h0001;
               case (st_ff)
                  RXS_IDLE:
                     if (!ser_txd_i[g]) // R7
                     begin
                        st_ff <= RXS_START;
                        cnt_ff <= {1'b0, div[15:1]};
                     end
                  RXS_START:
                     if (cnt_ff == 16'h0000)
                     begin
                        st_ff <= ser_txd_i[g] ? RXS_IDLE : RXS_DATA;
                        nb_ff <= 3'h0;
                     end
                  RXS_DATA:
                     if (cnt_ff == 16'h0000)
                     begin
                        sh_ff <= {ser_txd_i[g], sh_ff[7:1]}; // R19
                        nb_ff <= nb_ff + 3'h1;
                        if (nb_ff == 3'h7)
                           st_ff <= RXS_STOP; // R9
                     end
                  RXS_STOP:
                     if (cnt_ff == 16'h0000)
                     begin
                        st_ff <= RXS_IDLE;
                        rx_stb_ff[g] <= ser_txd_i[g];
                        rx_byte_ff[g] <= sh_ff;
                     end
                  default:
                     st_ff <= RXS_IDLE;
               endcase
            end
         end
      end
   endgenerate

   // pins: DCE drives RXD; RTS looped to CTS; DSR held high; RS-485 pair
   always_ff @(posedge sys_clk_i)
   begin
      if (!nrst_i)
      begin
         ser_rxd_o <= '1;
         ser_cts_o <= '0;
         ser_dsr_o <= '0;
         rs485_a_o <= 2'h0;
         rs485_b_o <= 2'h3;
      end
      else
      begin
         ser_rxd_o <= {tx_line_ff[4], tx_line_ff[1:0]}; // R7
         ser_cts_o <= ser_rts_i; // R8
         ser_dsr_o <= '1; // R8
         rs485_a_o <= ~tx_line_ff[3:2]; // R13
         rs485_b_o <= tx_line_ff[3:2]; // R13
      end
   end

   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!nrst_i);

   sequence s_req_seen;
      rx_stb_ff[0] && !cfg_ff[0].cont && rx_byte_ff[0] == cfg_ff[0].req;
   endsequence
   sequence s_frame_head;
      tx_st_ff[0] == TXS_IDLE && tx_load[0];
   endsequence

   AST_REQ_START: assert property ( // R2
      s_req_seen and (!msg_act_ff[0] && mlen_ff[cfg_ff[0].fmt] != 6'h00) |=> msg_act_ff[0])
      else $error("request char did not start a message");
   // an idle transmitter must start the asterisk at once
   AST_STAR_REPLY: assert property ( // R5
      rx_stb_ff[0] && rx_byte_ff[0] != cfg_ff[0].req && tx_st_ff[0] == TXS_IDLE &&
      !msg_act_ff[0] && !star_ff[0] |=> star_ff[0] ##0 tx_load[0])
      else $error("invalid char not answered");
   AST_RESET_REQ: assert property ($rose(nrst_i) |-> cfg_ff[1].req == REQ_CHAR_RST) // R4
      else $error("request char not T after reset");
   AST_START_BIT: assert property ( // R19
      s_frame_head |=> tx_line_ff[0] == 1'b0 && tx_st_ff[0] == TXS_START)
      else $error("frame did not open with start bit");
   AST_STOP_MARK: assert property (tx_st_ff[2] == TXS_STOP |-> tx_line_ff[2]) // R19
      else $error("stop bit not mark");
   AST_EIGHT_BITS: assert property ( // R9
      $rose(tx_st_ff[0] == TXS_STOP) |-> $past(g_tx[0].nb_ff) == 3'h7)
      else $error("frame did not carry eight data bits");
   AST_TICK_STREAM: assert property ( // R18
      pps_tick_i && !msg_act_ff[2] && mlen_ff[cfg_ff[2].fmt] != 6'h00 |=> msg_act_ff[2])
      else $error("remote output missed the tick");
   AST_RS485_POL: assert property ( // R13
      rs485_b_o[0] == $past(tx_line_ff[2]) && rs485_a_o[0] != rs485_b_o[0])
      else $error("RS-485 polarity wrong");
   AST_XOFF_HOLD: assert property ( // R16
      xoff_ff && tx_st_ff[4] == TXS_IDLE |=> tx_st_ff[4] == TXS_IDLE)
      else $error("setup port sent while paused");
   // handshake outputs still show reset values on the first edge after release
   AST_CTS_LOOP: assert property ( // R8
      $past(nrst_i) |-> ser_cts_o == $past(ser_rts_i) && ser_dsr_o == '1)
      else $error("handshake lines wrong");
endmodule : tsop_top

// [include/tsop_pkg.sv]
package tsop_pkg;
   localparam int CLK_HZ = 250_000_000;
   localparam int SETUP_BAUD = 9600;
   localparam logic [15:0] SETUP_DIV = 16'(CLK_HZ / SETUP_BAUD);
   localparam int N_TIME = 2;
   localparam int N_OUT = 4;
   localparam int N_TX = 5;
   localparam int N_RX = 3;
   localparam int N_FMT = 6;
   localparam int MSG_BYTES = 32;
   localparam logic [2:0] FMT_MAX = 3'h5;
   localparam logic [7:0] REQ_CHAR_RST = 8'h54;
   localparam logic [7:0] STAR_CHAR = 8'h2A;
   localparam logic [7:0] XON_CHAR = 8'h11;
   localparam logic [7:0] XOFF_CHAR = 8'h13;
   localparam logic [7:0] REQ_LO = 8'h21;
   localparam logic [7:0] REQ_HI = 8'h7E;
   localparam logic [7:0] LOWER_LO = 8'h61;
   localparam logic [7:0] LOWER_HI = 8'h7A;
   localparam logic [11:0] ADDR_STAT = 12'h000;
   localparam logic [11:0] ADDR_SETUP_TX = 12'h004;
   localparam logic [11:0] ADDR_SETUP_RX = 12'h008;
   localparam logic [11:0] ADDR_CFG = 12'h010;
   localparam logic [11:0] ADDR_DIV = 12'h020;
   localparam logic [11:0] ADDR_MLEN = 12'h040;
   localparam logic [11:0] ADDR_MSG = 12'h400;
   localparam logic [11:0] ADDR_MSG_END = 12'h700;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int CFG_FMT_LSB = 0;
   localparam int CFG_CONT_BIT = 3;
   localparam int CFG_REQ_LSB = 8;
   localparam int CFG_UTC_LSB = 16;
   localparam int RX_VALID_BIT = 8;
   localparam int RX_OVR_BIT = 9;

   typedef enum logic [1:0] {
      TXS_IDLE = 2'b00,
      TXS_START = 2'b01,
      TXS_DATA = 2'b10,
      TXS_STOP = 2'b11
   } tsop_txs_t;

   typedef enum logic [1:0] {
      RXS_IDLE = 2'b00,
      RXS_START = 2'b01,
      RXS_DATA = 2'b10,
      RXS_STOP = 2'b11
   } tsop_rxs_t;

   typedef struct packed {
      logic [7:0] utc;
      logic [7:0] req;
      logic cont;
      logic [2:0] fmt;
      logic [15:0] div;
   } tsop_cfg_t;
endpackage : tsop_pkg

// [verif/tsop_term.sv]
`timescale 1ns/100ps
module tsop_term
#(
   parameter int DIV = 4
)(
   input wire logic sys_clk_i,
   input wire logic line_i,
   output logic line_o
);
   initial line_o = 1'b1;
   // start bit, eight data bits lsb first, one stop bit, no parity
   task automatic send_byte(input logic [7:0] b);
      for (int i = 0; i < 10; i++)
      begin
         line_o <= (i == 0) ? 1'b0 : ((i == 9) ? 1'b1 : b[i-1]);
         repeat (DIV) @(posedge sys_clk_i);
      end
   endtask : send_byte
   task automatic recv_byte(output logic [7:0] b, output logic ok);
      int n;
      n = 0;
      while (line_i !== 1'b0 && n < 4000)
      begin
         @(posedge sys_clk_i);
         n++;
      end
      repeat (DIV / 2) @(posedge sys_clk_i);
      for (int i = 0; i < 8; i++)
      begin
         repeat (DIV) @(posedge sys_clk_i);
         b[i] = line_i;
      end
      repeat (DIV) @(posedge sys_clk_i);
      ok = (n < 4000) && (line_i === 1'b1);
   endtask : recv_byte
endmodule : tsop_term

// [verif/time_serial_output_ports_test.sv]
`timescale 1ns/100ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin errors++; \
   $display("Error %0t: got %h expected %h", $time, (a), (e)); end end
module time_serial_output_ports_test;
   import tsop_pkg::*;
   localparam int BD = 4;
   logic sys_clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic pps = 1'b0;
   logic [11:0] awaddr = '0;
   logic [11:0] araddr = '0;
   logic [31:0] wdata = '0;
   logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
   logic [2:0] rts = '0;
   logic [2:0] rxd, cts, dsr;
   logic [1:0] bresp, rresp, ra, rb;
   logic [31:0] rdata;
   logic awr, wr, bv, arr, rv, t0_line;
   int errors = 0;
   int tests_run = 0;
   int cyc = 0;
   always #2 sys_clk_i = ~sys_clk_i;
   tsop_top #(.FIFO_DEPTH(2)) dut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .pps_tick_i(pps),
      .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
      .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr),
      .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(bready),
      .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
      .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv),
      .s_axi_rready_i(rready), .ser_txd_i({2'b11, t0_line}), .ser_rxd_o(rxd),
      .ser_rts_i(rts), .ser_cts_o(cts), .ser_dsr_o(dsr), .rs485_a_o(ra), .rs485_b_o(rb));
   tsop_term #(.DIV(BD)) t0 (.sys_clk_i(sys_clk_i), .line_i(rxd[0]), .line_o(t0_line));
   tsop_term #(.DIV(BD)) rem (.sys_clk_i(sys_clk_i), .line_i(rb[0]), .line_o());
   task automatic give_verdict();
      $display("errors=%0d tests_run=%0d", errors, tests_run);
      if (errors == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : give_verdict
   always @(posedge sys_clk_i)
   begin
      cyc <= cyc + 1;
      if (cyc > 4)
         `CHK(ra ^ rb, 2'b11)
      if (cyc == 20000)
      begin
         errors++;
         give_verdict();
      end
   end
   task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      awaddr <= a;
      wdata <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge sys_clk_i);
         if (awr) awv <= 1'b0;
         if (wr) wv <= 1'b0;
      end while (bv !== 1'b1);
      bready <= 1'b0;
      `CHK(bresp, er)
      @(posedge sys_clk_i);
   endtask : axw
   task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      araddr <= a;
      arv <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge sys_clk_i);
         if (arr) arv <= 1'b0;
      end while (rv !== 1'b1);
      rready <= 1'b0;
      d = rdata;
      r = rresp;
      @(posedge sys_clk_i);
   endtask : axr
   // one character to time port 0, one character back
   task automatic ask(input logic [7:0] c, input logic [7:0] e);
      logic [7:0] b;
      logic ok;
      fork
         t0.send_byte(c);
         t0.recv_byte(b, ok);
      join
      `CHK({ok, b}, {1'b1, e})
   endtask : ask
   initial
   begin
      logic [31:0] d;
      logic [1:0] r;
      logic [7:0] b;
      logic ok;
      logic [7:0] b2;
      logic ok2;
      repeat (2) @(posedge sys_clk_i);
      nrst_i <= 1'b1;
      rts <= 3'b101;
      repeat (3) @(posedge sys_clk_i);
      `CHK(dsr, 3'b111)
      `CHK(cts, 3'b101)
      `CHK(rxd, 3'b111)
      axr(ADDR_CFG, d, r);
      `CHK(d[15:8], REQ_CHAR_RST)
      axr(12'h0FC, d, r);
      `CHK(r, RESP_SLVERR)
      axw(12'h0FC, 32'h0, RESP_SLVERR);
      axw(ADDR_DIV, 32'(BD), RESP_OKAY);
      axw(ADDR_DIV + 12'h008, 32'(BD), RESP_OKAY);
      axw(ADDR_MLEN, 32'h1, RESP_OKAY);
      axw(ADDR_MSG, 32'h41, RESP_OKAY);
      ask(8'h54, 8'h41);
      axw(ADDR_CFG, 32'h00002300, RESP_OKAY);
      ask(8'h23, 8'h41);
      ask(8'h54, STAR_CHAR);
      axw(ADDR_CFG, 32'h00002308, RESP_OKAY);
      fork
         begin
            pps <= 1'b1;
            @(posedge sys_clk_i);
            pps <= 1'b0;
         end
         rem.recv_byte(b, ok);
         t0.recv_byte(b2, ok2);
      join
      `CHK({ok, b}, 9'h141)
      `CHK({ok2, b2}, 9'h141)
      give_verdict();
   end
endmodule : time_serial_output_ports_test
